//--- rtl/tsr_pkg.sv
package tsr_pkg;

	// Core clock rate and conversion period
	localparam longint TSR_CLK_HZ = 64'd25000000;
	localparam longint TSR_CONV_PERIOD_MS = 64'd250;
	localparam int TSR_CONV_CYCLES = int'((TSR_CONV_PERIOD_MS * TSR_CLK_HZ) / 64'd1000);

	// Serial slave address, upper four bits fixed, low three from pins
	localparam logic [3:0] TSR_ADDR_HI = 4'h3;

	// Register pointer codes
	localparam logic [3:0] TSR_PTR_RSVD = 4'h0;
	localparam logic [3:0] TSR_PTR_CFG = 4'h1;
	localparam logic [3:0] TSR_PTR_UPPER = 4'h2;
	localparam logic [3:0] TSR_PTR_LOWER = 4'h3;
	localparam logic [3:0] TSR_PTR_CRIT = 4'h4;
	localparam logic [3:0] TSR_PTR_AMB = 4'h5;
	localparam logic [3:0] TSR_PTR_MAKER = 4'h6;
	localparam logic [3:0] TSR_PTR_PART = 4'h7;
	localparam logic [3:0] TSR_PTR_RES = 4'h8;

	// Fixed read values; identity values are arbitrary
	localparam logic [15:0] TSR_RSVD_VAL = 16'h001f;
	localparam logic [15:0] TSR_MAKER_ID = 16'h00a5;
	localparam logic [15:0] TSR_PART_ID = 16'h0e01;

	// Limit field mask: sign at bit 12, quarter degree at bit 2
	localparam logic [15:0] TSR_LIMIT_MASK = 16'h1ffc;

	// Setup register bit positions
	localparam int TSR_CFG_LOW_POWER_HALT = 8;
	localparam int TSR_CFG_CLOCK = 7;
	localparam int TSR_CFG_WLOCK = 6;
	localparam int TSR_CFG_ICLR = 5;
	localparam int TSR_CFG_STAT = 4;
	localparam int TSR_CFG_CNT = 3;
	localparam int TSR_CFG_SEL = 2;
	localparam int TSR_CFG_POL = 1;
	localparam int TSR_CFG_MOD = 0;

	// Ambient flag positions
	localparam int TSR_AMB_CRIT = 15;
	localparam int TSR_AMB_UP = 14;
	localparam int TSR_AMB_LO = 13;

	// Reset values
	localparam logic [7:0] TSR_PTR_RST = 8'h00;
	localparam logic [1:0] TSR_RES_RST = 2'h3;
	localparam logic [15:0] TSR_LIMIT_RST = 16'h0000;
	localparam logic [15:0] TSR_AMB_RST = 16'h0000;

	// Serial engine states, Gray along the usual path
	typedef enum logic [2:0] {
		TSR_IDLE = 3'h0,
		TSR_ADDR = 3'h1,
		TSR_ACK_A = 3'h3,
		TSR_RX = 3'h2,
		TSR_ACK_RX = 3'h6,
		TSR_TX = 3'h7,
		TSR_ACK_TX = 3'h5
	} tsr_state_t;

	// Writable setup fields
	typedef struct packed {
		logic [1:0] hyst;
		logic low_power_halt;
		logic crit_lock;
		logic win_lock;
		logic alert_cnt;
		logic alert_sel;
		logic alert_pol;
		logic alert_mod;
	} tsr_cfg_t;

	localparam tsr_cfg_t TSR_CFG_RST = '0;

endpackage

//--- rtl/tsr_regbank.sv
`timescale 1ns/10ps
module tsr_regbank
	import tsr_pkg::*;
#(
	parameter int CONV_PERIOD_CYCLES = TSR_CONV_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [2:0] addr_pin,
	input wire logic [12:0] conv_sample,
	output logic alert_out,
	output logic alert_oe_n
);

	// Synchronisers for pins
	logic [1:0] scl_s, sda_s;
	logic [2:0] addr_s1, addr_q;
	logic scl_prev, sda_prev;

	// Serial engine state
	tsr_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d; // Bit counter
	logic [7:0] sh_q, sh_d; // Receive shifter
	logic [1:0] idx_q, idx_d; // Byte index in a write
	logic rw_q, rw_d; // Read request
	logic ack_q, ack_d; // Master acknowledged last byte
	logic [7:0] msb_q, msb_d; // Held upper data byte
	logic drv_q, drv_d; // Pull SDA low
	logic [15:0] tx_q, tx_d; // Transmit shifter
	logic [7:0] ptr_q, ptr_d; // Register pointer
	logic wr_q, wr_d; // Register write pulse
	logic [15:0] wdat_q, wdat_d; // Register write data

	// Register bank state
	tsr_cfg_t cfg_q, cfg_d;
	logic [15:0] upper_q, upper_d, lower_q, lower_d, crit_q, crit_d, amb_q, amb_d;
	logic [1:0] res_q, res_d;
	logic stat_q, stat_d; // Alert status
	logic cond_q; // Alert condition last cycle
	logic [31:0] conv_cnt_q, conv_cnt_d;
	logic alert_oe_n_d;

	// Decoded events and helpers
	logic scl_rise, scl_fall, start, stop, conv_tick, cond, int_clr, lock_any;
	logic [15:0] rd_word;
	logic [12:0] smp;

	// Two flops per pin, then a third on SCL and SDA for edge finding
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			addr_s1 <= 3'h0;
			addr_q <= 3'h0;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			scl_prev <= scl_s[1];
			sda_prev <= sda_s[1];
			addr_s1 <= addr_pin;
			addr_q <= addr_s1;
		end
	end

	// Bus events from synchronised levels
	assign scl_rise = scl_s[1] & ~scl_prev;
	assign scl_fall = ~scl_s[1] & scl_prev;
	assign start = scl_s[1] & scl_prev & sda_prev & ~sda_s[1];
	assign stop = scl_s[1] & scl_prev & ~sda_prev & sda_s[1];

	// Read multiplexer; upper pointer bits nonzero read as zero
	always_comb begin
		rd_word = 16'h0000;
		if (ptr_q[7:4] == 4'h0) begin
			case (ptr_q[3:0])
				TSR_PTR_RSVD: rd_word = TSR_RSVD_VAL;
				TSR_PTR_CFG: rd_word = {5'h00, cfg_q.hyst, cfg_q.low_power_halt, cfg_q.crit_lock,
					cfg_q.win_lock, 1'b0, stat_q, cfg_q.alert_cnt, cfg_q.alert_sel,
					cfg_q.alert_pol, cfg_q.alert_mod};
				TSR_PTR_UPPER: rd_word = upper_q;
				TSR_PTR_LOWER: rd_word = lower_q;
				TSR_PTR_CRIT: rd_word = crit_q;
				TSR_PTR_AMB: rd_word = amb_q;
				TSR_PTR_MAKER: rd_word = TSR_MAKER_ID;
				TSR_PTR_PART: rd_word = TSR_PART_ID;
				TSR_PTR_RES: rd_word = {6'h00, res_q, 8'h00};
				default: rd_word = 16'h0000;
			endcase
		end
	end

	// Serial engine next state
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		idx_d = idx_q;
		rw_d = rw_q;
		ack_d = ack_q;
		msb_d = msb_q;
		drv_d = drv_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		wr_d = 1'b0;
		wdat_d = wdat_q;
		if (start) begin
			// Start or repeated start restarts address phase
			st_d = TSR_ADDR;
			cnt_d = 4'h0;
			idx_d = 2'h0;
			drv_d = 1'b0;
		end else if (stop) begin
			st_d = TSR_IDLE;
			drv_d = 1'b0;
		end else begin
			case (st_q)
				TSR_ADDR: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s[1]};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (sh_q[7:1] == {TSR_ADDR_HI, addr_q}) begin
							st_d = TSR_ACK_A;
							drv_d = 1'b1;
							rw_d = sh_q[0];
							tx_d = rd_word; // Snapshot from kept pointer
						end else begin
							st_d = TSR_IDLE;
						end
					end
				end
				TSR_ACK_A: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin
							st_d = TSR_TX;
							drv_d = ~tx_q[15];
						end else begin
							st_d = TSR_RX;
							drv_d = 1'b0;
						end
					end
				end
				TSR_RX: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s[1]};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						st_d = TSR_ACK_RX;
						drv_d = 1'b1;
						if (idx_q != 2'h3) begin
							idx_d = idx_q + 2'h1;
						end
						if (idx_q == 2'h0) begin
							ptr_d = sh_q;
						end else if (idx_q == 2'h1) begin
							msb_d = sh_q;
							// Resolution takes a single data byte
							if (ptr_q == {4'h0, TSR_PTR_RES}) begin
								wr_d = 1'b1;
								wdat_d = {8'h00, sh_q};
							end
						end else if (idx_q == 2'h2) begin
							wr_d = 1'b1;
							wdat_d = {msb_q, sh_q};
						end
					end
				end
				TSR_ACK_RX: begin
					if (scl_fall) begin
						st_d = TSR_RX;
						drv_d = 1'b0;
						cnt_d = 4'h0;
					end
				end
				TSR_TX: begin
					if (scl_fall) begin
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == 4'h7) begin
							st_d = TSR_ACK_TX;
							drv_d = 1'b0;
						end else begin
							tx_d = {tx_q[14:0], 1'b0};
							drv_d = ~tx_q[14];
						end
					end
				end
				TSR_ACK_TX: begin
					if (scl_rise) begin
						ack_d = ~sda_s[1];
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (ack_q) begin
							st_d = TSR_TX;
							tx_d = {tx_q[14:0], 1'b0};
							drv_d = ~tx_q[14];
						end else begin
							st_d = TSR_IDLE;
						end
					end
				end
				default: st_d = TSR_IDLE;
			endcase
		end
	end

	// Serial engine registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_q <= TSR_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			idx_q <= 2'h0;
			rw_q <= 1'b0;
			ack_q <= 1'b0;
			msb_q <= 8'h00;
			drv_q <= 1'b0;
			tx_q <= 16'h0000;
			ptr_q <= TSR_PTR_RST;
			wr_q <= 1'b0;
			wdat_q <= 16'h0000;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			idx_q <= idx_d;
			rw_q <= rw_d;
			ack_q <= ack_d;
			msb_q <= msb_d;
			drv_q <= drv_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			wr_q <= wr_d;
			wdat_q <= wdat_d;
			sda_out <= 1'b0;
			sda_oe_n <= ~drv_d;
		end
	end

	// Helpers for register bank
	assign lock_any = cfg_q.crit_lock | cfg_q.win_lock;
	assign conv_tick = ~cfg_q.low_power_halt && conv_cnt_q == 32'(CONV_PERIOD_CYCLES - 1);
	assign int_clr = wr_q && ptr_q == {4'h0, TSR_PTR_CFG} && wdat_q[TSR_CFG_ICLR]
		&& ~cfg_q.low_power_halt;
	assign cond = amb_q[TSR_AMB_CRIT]
		| (~cfg_q.alert_sel & (amb_q[TSR_AMB_UP] | amb_q[TSR_AMB_LO]));

	// Register bank, conversion timer and alert next values
	always_comb begin
		cfg_d = cfg_q;
		upper_d = upper_q;
		lower_d = lower_q;
		crit_d = crit_q;
		res_d = res_q;
		amb_d = amb_q;
		stat_d = stat_q;
		conv_cnt_d = conv_cnt_q;
		alert_oe_n_d = alert_oe_n;
		smp = conv_sample;
		if (wr_q && ptr_q[7:4] == 4'h0) begin
			case (ptr_q[3:0])
				TSR_PTR_CFG: begin
					cfg_d.crit_lock = cfg_q.crit_lock | wdat_q[TSR_CFG_CLOCK];
					cfg_d.win_lock = cfg_q.win_lock | wdat_q[TSR_CFG_WLOCK];
					cfg_d.low_power_halt = lock_any ? (cfg_q.low_power_halt & wdat_q[TSR_CFG_LOW_POWER_HALT])
						: wdat_q[TSR_CFG_LOW_POWER_HALT];
					if (!lock_any) begin
						cfg_d.hyst = wdat_q[10:9];
						cfg_d.alert_cnt = wdat_q[TSR_CFG_CNT];
						cfg_d.alert_pol = wdat_q[TSR_CFG_POL];
						cfg_d.alert_mod = wdat_q[TSR_CFG_MOD];
					end
					if (!cfg_q.win_lock) begin
						cfg_d.alert_sel = wdat_q[TSR_CFG_SEL];
					end
				end
				TSR_PTR_UPPER: if (!cfg_q.win_lock) begin
					upper_d = wdat_q & TSR_LIMIT_MASK;
				end
				TSR_PTR_LOWER: if (!cfg_q.win_lock) begin
					lower_d = wdat_q & TSR_LIMIT_MASK;
				end
				TSR_PTR_CRIT: if (!cfg_q.crit_lock) begin
					crit_d = wdat_q & TSR_LIMIT_MASK;
				end
				TSR_PTR_RES: res_d = wdat_q[1:0];
				default: res_d = res_q; // Reserved and read-only: ignored
			endcase
		end
		// Timer runs only outside halt
		if (cfg_q.low_power_halt) begin
			conv_cnt_d = 32'h0;
		end else if (conv_tick) begin
			conv_cnt_d = 32'h0;
		end else begin
			conv_cnt_d = conv_cnt_q + 32'h1;
		end
		// Whole word with flags loads at once
		if (conv_tick) begin
			case (res_q)
				2'h0: smp = conv_sample & 13'h1ff8;
				2'h1: smp = conv_sample & 13'h1ffc;
				2'h2: smp = conv_sample & 13'h1ffe;
				default: smp = conv_sample;
			endcase
			amb_d = {$signed(smp) >= $signed(crit_q[12:0]),
				$signed(smp) > $signed(upper_q[12:0]),
				$signed(smp) < $signed(lower_q[12:0]), smp};
		end
		// Alert status: comparator follows, interrupt latches; set beats clear
		if (!cfg_q.low_power_halt) begin
			if (!cfg_q.alert_mod) begin
				stat_d = cond;
			end else begin
				stat_d = (stat_q & ~int_clr) | (cond & ~cond_q);
			end
			alert_oe_n_d = ~((cfg_q.alert_cnt & stat_q) ^ cfg_q.alert_pol);
		end else if (cfg_q.alert_mod && wr_q && ptr_q == {4'h0, TSR_PTR_CFG}
			&& wdat_q[TSR_CFG_ICLR]) begin
			stat_d = 1'b0;
		end
	end

	// Register bank registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cfg_q <= TSR_CFG_RST;
			upper_q <= TSR_LIMIT_RST;
			lower_q <= TSR_LIMIT_RST;
			crit_q <= TSR_LIMIT_RST;
			res_q <= TSR_RES_RST;
			amb_q <= TSR_AMB_RST;
			stat_q <= 1'b0;
			cond_q <= 1'b0;
			conv_cnt_q <= 32'h0;
			alert_out <= 1'b0;
			alert_oe_n <= 1'b1;
		end else begin
			cfg_q <= cfg_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
			crit_q <= crit_d;
			res_q <= res_d;
			amb_q <= amb_d;
			stat_q <= stat_d;
			cond_q <= cond;
			conv_cnt_q <= conv_cnt_d;
			alert_out <= 1'b0;
			alert_oe_n <= alert_oe_n_d;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_byte_end;
		st_q == TSR_RX && scl_fall && cnt_q == 4'h8;
	endsequence

	property p_amb_hold;
		!conv_tick |=> $stable(amb_q);
	endproperty
	a_amb_hold: assert property (p_amb_hold) else $error("ambient changed off tick");

	property p_crit_flag;
		conv_tick |=> amb_q[15] == ($signed(amb_q[12:0]) >= $signed($past(crit_q[12:0])));
	endproperty
	a_crit_flag: assert property (p_crit_flag) else $error("critical flag wrong");

	property p_lock_sticky;
		cfg_q.crit_lock |=> cfg_q.crit_lock;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

	property p_win_sticky;
		cfg_q.win_lock |=> cfg_q.win_lock;
	endproperty
	a_win_sticky: assert property (p_win_sticky) else $error("window lock cleared");

	property p_win_locked;
		wr_q && cfg_q.win_lock |=> $stable(upper_q) && $stable(lower_q);
	endproperty
	a_win_locked: assert property (p_win_locked) else $error("window written");

	property p_crit_locked;
		wr_q && cfg_q.crit_lock |=> $stable(crit_q);
	endproperty
	a_crit_locked: assert property (p_crit_locked) else $error("locked limit written");

	property p_halt;
		cfg_q.low_power_halt |=> conv_cnt_q == 32'h0 && $stable(amb_q);
	endproperty
	a_halt: assert property (p_halt) else $error("conversion during halt");

	property p_limit_bits;
		((upper_q | lower_q | crit_q) & ~TSR_LIMIT_MASK) == 16'h0000;
	endproperty
	a_limit_bits: assert property (p_limit_bits) else $error("limit reserved bit set");

	property p_iclr_zero;
		ptr_q == {4'h0, TSR_PTR_CFG} |-> rd_word[TSR_CFG_ICLR] == 1'b0;
	endproperty
	a_iclr_zero: assert property (p_iclr_zero) else $error("clear bit read as one");

	property p_ptr_kept;
		!(st_q == TSR_RX && scl_fall && cnt_q == 4'h8 && idx_q == 2'h0) |=> $stable(ptr_q);
	endproperty
	a_ptr_kept: assert property (p_ptr_kept) else $error("pointer changed");

	property p_byte_ack;
		s_byte_end |=> st_q == TSR_ACK_RX && !sda_oe_n;
	endproperty
	a_byte_ack: assert property (p_byte_ack) else $error("byte not acknowledged");

	property p_rsvd;
		ptr_q == TSR_PTR_RST |-> rd_word == TSR_RSVD_VAL;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved slot wrong");

	property p_res_half;
		conv_tick && res_q == 2'h0 |=> amb_q[2:0] == 3'h0;
	endproperty
	a_res_half: assert property (p_res_half) else $error("resolution not applied");

endmodule // tsr_regbank

//--- verification/test_tsr_regbank.sv
`timescale 1ns/10ps
// Self-checking bench for the sensor register bank
module test_tsr_regbank
	import tsr_pkg::*;
;
	localparam int CONV_CYC = 50; // Shortened conversion period
	localparam int CEIL = 60000; // Cycle ceiling for a hung run
	localparam logic [6:0] DEV = {TSR_ADDR_HI, 3'h5}; // Address with straps at 5
	logic core_clk; // Core clock
	logic reset; // Asynchronous reset
	logic scl_line, sda_rel, sda_line, sda_out, sda_oe_n; // Serial bus pins
	logic alert_out, alert_oe_n, alert_line; // Alarm pin and its pulled-up level
	logic [12:0] conv_sample; // Converter result
	int n_fail, n_compared, cycles; // Counters
	logic ok; // All bytes acknowledged
	logic [15:0] got; // Read data
	// Pointer, write word, write bytes, read bytes, sample, expected read
	typedef struct packed {
		logic [7:0] p;
		logic [15:0] w;
		logic [1:0] wb;
		logic [1:0] rb;
		logic [12:0] smp;
		logic [15:0] e;
	} tsr_row_t;
	tsr_row_t rows [18] = '{
		'{8'h02, 16'hffff, 2'd2, 2'd2, 13'h0000, 16'h1ffc},
		'{8'h03, 16'h0123, 2'd2, 2'd2, 13'h0000, 16'h0120},
		'{8'h04, 16'h1abc, 2'd2, 2'd2, 13'h0000, 16'h1abc},
		'{8'h00, 16'h1234, 2'd2, 2'd2, 13'h0000, TSR_RSVD_VAL},
		'{8'h06, 16'h1111, 2'd2, 2'd2, 13'h0000, TSR_MAKER_ID},
		'{8'h07, 16'h2222, 2'd2, 2'd2, 13'h0000, TSR_PART_ID},
		'{8'h01, 16'h0020, 2'd2, 2'd2, 13'h0000, 16'h0010},
		'{8'h08, 16'h0001, 2'd1, 2'd1, 13'h0000, 16'h0001},
		'{8'h02, 16'h0190, 2'd2, 2'd2, 13'h0195, 16'h0190},
		'{8'h03, 16'h0100, 2'd2, 2'd2, 13'h0195, 16'h0100},
		'{8'h04, 16'h0200, 2'd2, 2'd2, 13'h0195, 16'h0200},
		'{8'h05, 16'h5555, 2'd2, 2'd2, 13'h0195, 16'h4194},
		'{8'h08, 16'h0003, 2'd1, 2'd1, 13'h0203, 16'h0003},
		'{8'h05, 16'h0000, 2'd0, 2'd2, 13'h0203, 16'hc203},
		'{8'h08, 16'h0000, 2'd1, 2'd1, 13'h1ff0, 16'h0000},
		'{8'h05, 16'h0000, 2'd0, 2'd2, 13'h1ff0, 16'h3ff0},
		'{8'h08, 16'h0002, 2'd1, 2'd1, 13'h0150, 16'h0002},
		'{8'h05, 16'h0000, 2'd0, 2'd2, 13'h0150, 16'h0150}
	};

	// Open-drain lines with pull-ups
	assign sda_line = sda_rel & (sda_oe_n | sda_out);
	assign alert_line = alert_oe_n | alert_out;

	// Clock, 40 ns period
	always #20 core_clk = ~core_clk;

	tsr_regbank #(.CONV_PERIOD_CYCLES(CONV_CYC)) tsr_regbank_inst (
		.core_clk(core_clk),
		.reset(reset),
		.scl_in(scl_line),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.addr_pin(3'h5),
		.conv_sample(conv_sample),
		.alert_out(alert_out),
		.alert_oe_n(alert_oe_n)
	);

	tsr_host_model tsr_host_model_inst (
		.core_clk(core_clk),
		.sda_line(sda_line),
		.scl_line(scl_line),
		.sda_rel(sda_rel)
	);

	// Word comparison
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Single bit comparison
	task automatic chk1(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Register write; zero bytes gives a pointer-only write
	task automatic wr(input logic [7:0] p, input logic [15:0] d, input int nb);
		tsr_host_model_inst.write_reg(DEV, p, d, nb, ok);
		chk1("write ack", 1'b1, ok);
	endtask

	// Read from the retained pointer and compare
	task automatic rd(input int nb, input logic [15:0] e);
		tsr_host_model_inst.read_reg(DEV, nb, got, ok);
		chk1("read ack", 1'b1, ok);
		chk16("read data", e, got);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Counts, verdict, end of run
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == CEIL) begin
			n_fail++;
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		conv_sample = 13'h0000;
		n_fail = 0;
		n_compared = 0;
		cycles = 0;
		wait_cyc(8);
		reset = 1'b0;
		rd(2, TSR_RSVD_VAL);
		// Table rows: write, then read back through the kept pointer
		for (int i = 0; i < 18; i++) begin
			conv_sample = rows[i].smp;
			wr(rows[i].p, rows[i].w, rows[i].wb);
			rd(rows[i].rb, rows[i].e);
		end
		// Halt freezes the ambient value; registers stay reachable
		wr(1, 16'h0100, 2);
		conv_sample = 13'h0020;
		wait_cyc(150);
		wr(5, 16'h0000, 0);
		rd(2, 16'h0150);
		wr(1, 16'h0000, 2);
		wait_cyc(150);
		wr(5, 16'h0000, 0);
		rd(2, 16'h2020);
		// Comparator alarm follows the window
		wr(1, 16'h0008, 2);
		wait_cyc(4);
		chk1("alert below window", 1'b0, alert_line);
		conv_sample = 13'h0150;
		wait_cyc(120);
		chk1("alert in window", 1'b1, alert_line);
		// Interrupt mode latches until cleared
		wr(1, 16'h0009, 2);
		conv_sample = 13'h0203;
		wait_cyc(120);
		chk1("alert over critical", 1'b0, alert_line);
		conv_sample = 13'h0150;
		wait_cyc(120);
		chk1("alert latched", 1'b0, alert_line);
		wr(1, 16'h0029, 2);
		wait_cyc(4);
		chk1("alert cleared", 1'b1, alert_line);
		rd(2, 16'h0009);
		// Critical-only select with active-high polarity
		wr(1, 16'h000e, 2);
		conv_sample = 13'h0020;
		wait_cyc(120);
		chk1("alert window ignored", 1'b0, alert_line);
		conv_sample = 13'h0203;
		wait_cyc(120);
		chk1("alert critical high", 1'b1, alert_line);
		conv_sample = 13'h0150;
		wait_cyc(120);
		chk1("alert critical gone", 1'b0, alert_line);
		// Locks block limit writes and stay set
		wr(1, 16'h00c9, 2);
		wr(2, 16'h0aa0, 2);
		rd(2, 16'h0190);
		wr(4, 16'h0aa0, 2);
		rd(2, 16'h0200);
		wr(1, 16'h0000, 2);
		rd(2, 16'h00c9);
		// Reset in mid-run clears locks and pointer
		reset = 1'b1;
		wait_cyc(2);
		reset = 1'b0;
		wait_cyc(4);
		chk1("alert after reset", 1'b1, alert_line);
		rd(2, TSR_RSVD_VAL);
		wr(1, 16'h0000, 0);
		rd(2, 16'h0010);
		give_verdict();
	end
endmodule // test_tsr_regbank

//--- verification/tsr_host_model.sv
`timescale 1ns/10ps
// Serial bus host: makes the bus clock and pulls the data line low or releases it
module tsr_host_model
	import tsr_pkg::*;
(
	input wire logic core_clk,
	input wire logic sda_line,
	output logic scl_line,
	output logic sda_rel
);
	// Bus idle: clock stands high, data released to the pull-up
	initial begin
		scl_line = 1'b1;
		sda_rel = 1'b1;
	end

	// Moves happen on core clock falling edges only
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Start or repeated start: data falls while the clock is high
	task automatic bus_start();
		tick(2);
		sda_rel = 1'b1;
		tick(3);
		scl_line = 1'b1;
		tick(4);
		sda_rel = 1'b0;
		tick(3);
		scl_line = 1'b0;
	endtask

	// Stop: data rises while the clock is high, then the bus rests
	task automatic bus_stop();
		tick(2);
		sda_rel = 1'b0;
		tick(3);
		scl_line = 1'b1;
		tick(4);
		sda_rel = 1'b1;
		tick(4);
	endtask

	// One bit: 5 cycles low, 3 high (320 ns); line sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_rel = b;
		tick(3);
		scl_line = 1'b1;
		tick(2);
		r = sda_line;
		tick(1);
		scl_line = 1'b0;
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_seen);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack_seen);
	endtask

	// Address, pointer, then nb data bytes MSB first; ok when every byte was acknowledged
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
		input int nb, output logic ok);
		logic [7:0] rx;
		logic ak;
		bus_start();
		xfer_byte({a, 1'b0}, 1'b1, rx, ak);
		ok = (ak === 1'b0);
		// Callers keep pointer bits 7:4 zero; one table row writes the reserved code 0
		xfer_byte(p, 1'b1, rx, ak);
		ok = ok && (ak === 1'b0);
		for (int i = nb - 1; i >= 0; i--) begin
			xfer_byte(d[8*i +: 8], 1'b1, rx, ak);
			ok = ok && (ak === 1'b0);
		end
		bus_stop();
	endtask

	// Read nb bytes from the retained pointer; the last byte is refused to end the read
	task automatic read_reg(input logic [6:0] a, input int nb, output logic [15:0] d,
		output logic ok);
		logic [7:0] rx;
		logic ak;
		d = 16'h0000;
		bus_start();
		xfer_byte({a, 1'b1}, 1'b1, rx, ak);
		ok = (ak === 1'b0);
		for (int i = nb - 1; i >= 0; i--) begin
			xfer_byte(8'hff, (i == 0), rx, ak);
			d[8*i +: 8] = rx;
		end
		bus_stop();
	endtask
endmodule // tsr_host_model
